// ### design/ccx_cfg.svh
// Constants for the clock output crosspoint select block
// Operation
// [RULE1] Decode select into both output sources
// [RULE2] Derive video PLL off indications from select
// [RULE3] Software force overrides each off indication
// [RULE4] Select resets to 0000, A and B
// [RULE5] Frame-rate codes map to listed rates
// [RULE6] Frame-rate codes stored at 0x21..0x23
// [RULE7] Software avoids reserved select codes 1001..1111
`ifndef CCX_CFG_SVH
`define CCX_CFG_SVH

// Register offsets
`define CCX_ADDR_XPT 8'h09
`define CCX_ADDR_FORCE 8'h0a
`define CCX_ADDR_FR_IN 8'h21
`define CCX_ADDR_FR_A 8'h22
`define CCX_ADDR_FR_B 8'h23

// Reset values
`define CCX_XPT_RST 4'h0
`define CCX_FORCE_RST 4'h0
`define CCX_FR_RST 4'h0
`define CCX_RDATA_RST 8'h00
`define CCX_UNMAPPED 8'h00

// Force register fields
`define CCX_FRC_A_EN 0
`define CCX_FRC_A_VAL 1
`define CCX_FRC_B_EN 2
`define CCX_FRC_B_VAL 3

// Crosspoint select codes
`define CCX_XPT_AB 4'h0
`define CCX_XPT_RR 4'h1
`define CCX_XPT_AA 4'h2
`define CCX_XPT_BB 4'h3
`define CCX_XPT_BA 4'h4
`define CCX_XPT_RB 4'h5
`define CCX_XPT_AR 4'h6
`define CCX_XPT_RA 4'h7
`define CCX_XPT_BR 4'h8

// Frame-rate codes
`define CCX_FR_23_98 4'h0
`define CCX_FR_24 4'h1
`define CCX_FR_25 4'h2
`define CCX_FR_29_97 4'h3
`define CCX_FR_30 4'h4
`define CCX_FR_50 4'h5
`define CCX_FR_59_94 4'h6
`define CCX_FR_60 4'h7

// Frame rates in millihertz
`define CCX_MHZ_23_98 17'h05dac
`define CCX_MHZ_24 17'h05dc0
`define CCX_MHZ_25 17'h061a8
`define CCX_MHZ_29_97 17'h07512
`define CCX_MHZ_30 17'h07530
`define CCX_MHZ_50 17'h0c350
`define CCX_MHZ_59_94 17'h0ea24
`define CCX_MHZ_60 17'h0ea60
`define CCX_MHZ_NONE 17'h00000

`endif

// ### design/ccx_pkg.sv
// Types for the clock output crosspoint select block
package ccx_pkg;
  typedef enum logic [1:0] {
    CCX_SRC_REF,
    CCX_SRC_A,
    CCX_SRC_B,
    CCX_SRC_NONE
  } ccx_src_t;
endpackage

// ### design/ccx_xpt_decode.sv
// Combinational decoder of the crosspoint select code
`timescale 1ns/1ns
`include "ccx_cfg.svh"
module ccx_xpt_decode (
  input wire logic [3:0] sel_in,
  output ccx_pkg::ccx_src_t first_src_out,
  output ccx_pkg::ccx_src_t second_src_out,
  output logic a_off_out,
  output logic b_off_out,
  output logic reserved_out
);
  import ccx_pkg::*;

  // Source pair and off pair per code; reserved codes park both outputs
  always_comb begin
    first_src_out = CCX_SRC_NONE;
    second_src_out = CCX_SRC_NONE;
    a_off_out = 1'b0;
    b_off_out = 1'b0;
    reserved_out = 1'b0;
    case (sel_in)
      `CCX_XPT_AB: begin // RULE1
        first_src_out = CCX_SRC_A;
        second_src_out = CCX_SRC_B;
      end
      `CCX_XPT_RR: begin
        first_src_out = CCX_SRC_REF;
        second_src_out = CCX_SRC_REF;
        a_off_out = 1'b1; // RULE2
        b_off_out = 1'b1;
      end
      `CCX_XPT_AA: begin
        first_src_out = CCX_SRC_A;
        second_src_out = CCX_SRC_A;
        b_off_out = 1'b1; // RULE2
      end
      `CCX_XPT_BB: begin
        first_src_out = CCX_SRC_B;
        second_src_out = CCX_SRC_B;
        a_off_out = 1'b1; // RULE2
      end
      `CCX_XPT_BA: begin
        first_src_out = CCX_SRC_B;
        second_src_out = CCX_SRC_A;
      end
      `CCX_XPT_RB: begin
        first_src_out = CCX_SRC_REF;
        second_src_out = CCX_SRC_B;
        a_off_out = 1'b1;
      end
      `CCX_XPT_AR: begin
        first_src_out = CCX_SRC_A;
        second_src_out = CCX_SRC_REF;
        b_off_out = 1'b1;
      end
      `CCX_XPT_RA: begin
        first_src_out = CCX_SRC_REF;
        second_src_out = CCX_SRC_A;
        b_off_out = 1'b1;
      end
      `CCX_XPT_BR: begin
        first_src_out = CCX_SRC_B;
        second_src_out = CCX_SRC_REF;
        a_off_out = 1'b1;
      end
      default: begin
        // Undefined routing: nothing selected, no PLL turned off
        reserved_out = 1'b1;
      end
    endcase
  end
endmodule

// ### design/ccx_xpt.sv
// Crosspoint select registers, frame-rate codes and registered outputs
`timescale 1ns/1ns
`include "ccx_cfg.svh"
module ccx_xpt (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output ccx_pkg::ccx_src_t first_clock_output_src_out,
  output ccx_pkg::ccx_src_t second_clock_output_src_out,
  output logic video_pll_a_off_out,
  output logic video_pll_b_off_out,
  output logic xpt_reserved_out,
  output logic [16:0] in_frame_rate_mhz_out,
  output logic [16:0] pll_a_frame_rate_mhz_out,
  output logic [16:0] pll_b_frame_rate_mhz_out
);
  import ccx_pkg::*;

  logic [3:0] xpt_sel;
  logic [3:0] video_pll_off_force;
  logic [3:0] fr_in;
  logic [3:0] fr_a;
  logic [3:0] fr_b;
  ccx_src_t dec_first;
  ccx_src_t dec_second;
  logic dec_a_off;
  logic dec_b_off;
  logic dec_reserved;
  logic next_a_off;
  logic next_b_off;
  logic sel_hit;
  logic force_hit;
  logic fr_in_hit;
  logic fr_a_hit;
  logic fr_b_hit;

  // Address decode for the register port
  assign sel_hit = reg_addr_in == `CCX_ADDR_XPT;
  assign force_hit = reg_addr_in == `CCX_ADDR_FORCE;
  assign fr_in_hit = reg_addr_in == `CCX_ADDR_FR_IN;
  assign fr_a_hit = reg_addr_in == `CCX_ADDR_FR_A;
  assign fr_b_hit = reg_addr_in == `CCX_ADDR_FR_B;

  // Crosspoint select; software must keep it out of the reserved range
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      xpt_sel <= `CCX_XPT_RST; // RULE4
    end else if (reg_wr_in && sel_hit) begin
      xpt_sel <= reg_wdata_in[3:0]; // RULE7
    end
  end

  // Force enables and forced values for both off indications
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      video_pll_off_force <= `CCX_FORCE_RST;
    end else if (reg_wr_in && force_hit) begin
      video_pll_off_force <= reg_wdata_in[3:0]; // RULE3
    end
  end

  // Frame-rate code storage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fr_in <= `CCX_FR_RST;
      fr_a <= `CCX_FR_RST;
      fr_b <= `CCX_FR_RST;
    end else if (reg_wr_in) begin
      if (fr_in_hit) begin
        fr_in <= reg_wdata_in[3:0]; // RULE6
      end
      if (fr_a_hit) begin
        fr_a <= reg_wdata_in[3:0];
      end
      if (fr_b_hit) begin
        fr_b <= reg_wdata_in[3:0];
      end
    end
  end

  // Read path; unmapped offsets answer zero, upper nibble reads zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `CCX_RDATA_RST;
    end else if (reg_rd_in) begin
      if (sel_hit) begin
        reg_rdata_out <= {4'h0, xpt_sel};
      end else if (force_hit) begin
        reg_rdata_out <= {4'h0, video_pll_off_force};
      end else if (fr_in_hit) begin
        reg_rdata_out <= {4'h0, fr_in};
      end else if (fr_a_hit) begin
        reg_rdata_out <= {4'h0, fr_a};
      end else if (fr_b_hit) begin
        reg_rdata_out <= {4'h0, fr_b};
      end else begin
        reg_rdata_out <= `CCX_UNMAPPED;
      end
    end
  end

  ccx_xpt_decode u_dec (
    .sel_in(xpt_sel),
    .first_src_out(dec_first),
    .second_src_out(dec_second),
    .a_off_out(dec_a_off),
    .b_off_out(dec_b_off),
    .reserved_out(dec_reserved)
  );

  // Force wins over the decoded value whatever the select holds
  always_comb begin
    next_a_off = dec_a_off;
    next_b_off = dec_b_off;
    if (video_pll_off_force[`CCX_FRC_A_EN]) begin
      next_a_off = video_pll_off_force[`CCX_FRC_A_VAL]; // RULE3
    end
    if (video_pll_off_force[`CCX_FRC_B_EN]) begin
      next_b_off = video_pll_off_force[`CCX_FRC_B_VAL]; // RULE3
    end
  end

  // Registered routing; reset shows the default pairing A then B
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      first_clock_output_src_out <= CCX_SRC_A; // RULE4
      second_clock_output_src_out <= CCX_SRC_B;
      video_pll_a_off_out <= 1'b0;
      video_pll_b_off_out <= 1'b0;
      xpt_reserved_out <= 1'b0;
    end else begin
      first_clock_output_src_out <= dec_first; // RULE1
      second_clock_output_src_out <= dec_second;
      video_pll_a_off_out <= next_a_off; // RULE2
      video_pll_b_off_out <= next_b_off;
      xpt_reserved_out <= dec_reserved;
    end
  end

  // Code to rate; codes 8..15 carry no rate and give zero
  function automatic logic [16:0] ccx_rate(input logic [3:0] code);
    logic [16:0] r;
    r = `CCX_MHZ_NONE;
    case (code)
      `CCX_FR_23_98: r = `CCX_MHZ_23_98; // RULE5
      `CCX_FR_24: r = `CCX_MHZ_24;
      `CCX_FR_25: r = `CCX_MHZ_25;
      `CCX_FR_29_97: r = `CCX_MHZ_29_97;
      `CCX_FR_30: r = `CCX_MHZ_30;
      `CCX_FR_50: r = `CCX_MHZ_50;
      `CCX_FR_59_94: r = `CCX_MHZ_59_94;
      `CCX_FR_60: r = `CCX_MHZ_60;
      default: r = `CCX_MHZ_NONE;
    endcase
    return r;
  endfunction

  // Registered frame-rate values for the three lookup settings
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame_rate_mhz_out <= `CCX_MHZ_23_98;
      pll_a_frame_rate_mhz_out <= `CCX_MHZ_23_98;
      pll_b_frame_rate_mhz_out <= `CCX_MHZ_23_98;
    end else begin
      in_frame_rate_mhz_out <= ccx_rate(fr_in); // RULE6
      pll_a_frame_rate_mhz_out <= ccx_rate(fr_a);
      pll_b_frame_rate_mhz_out <= ccx_rate(fr_b);
    end
  end

  // Checks on routing, off indications and rates
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  chk_write_route: assert property ( // RULE1
    reg_wr_in && sel_hit && reg_wdata_in[3:0] == `CCX_XPT_BA |-> ##2
    first_clock_output_src_out == CCX_SRC_B && second_clock_output_src_out == CCX_SRC_A)
    else $error("select 0100 did not route B then A");
  chk_route_rr: assert property ( // RULE1
    xpt_sel == `CCX_XPT_RR |=>
    first_clock_output_src_out == CCX_SRC_REF && second_clock_output_src_out == CCX_SRC_REF)
    else $error("select 0001 did not route reference to both");
  chk_both_off: assert property ( // RULE2
    xpt_sel == `CCX_XPT_RR && video_pll_off_force == 4'h0 |=>
    video_pll_a_off_out && video_pll_b_off_out)
    else $error("select 0001 did not turn both PLLs off");
  chk_a_only_off: assert property ( // RULE2
    (xpt_sel == `CCX_XPT_BB || xpt_sel == `CCX_XPT_RB || xpt_sel == `CCX_XPT_BR)
    && video_pll_off_force == 4'h0 |=> video_pll_a_off_out && !video_pll_b_off_out)
    else $error("wrong off pair for an A-only code");
  chk_b_only_off: assert property ( // RULE2
    (xpt_sel == `CCX_XPT_AA || xpt_sel == `CCX_XPT_AR || xpt_sel == `CCX_XPT_RA)
    && video_pll_off_force == 4'h0 |=> !video_pll_a_off_out && video_pll_b_off_out)
    else $error("wrong off pair for a B-only code");
  chk_force_a: assert property ( // RULE3
    video_pll_off_force[`CCX_FRC_A_EN] |=>
    video_pll_a_off_out == $past(video_pll_off_force[`CCX_FRC_A_VAL]))
    else $error("forced A off value not applied");
  chk_force_b: assert property ( // RULE3
    video_pll_off_force[`CCX_FRC_B_EN] |=>
    video_pll_b_off_out == $past(video_pll_off_force[`CCX_FRC_B_VAL]))
    else $error("forced B off value not applied");
  chk_default_pair: assert property ( // RULE4
    xpt_sel == `CCX_XPT_RST && video_pll_off_force == 4'h0 |=>
    first_clock_output_src_out == CCX_SRC_A && second_clock_output_src_out == CCX_SRC_B
    && !video_pll_a_off_out && !video_pll_b_off_out)
    else $error("default select not A then B with PLLs on");
  chk_rate_5994: assert property ( // RULE5
    reg_wr_in && fr_b_hit && reg_wdata_in[3:0] == `CCX_FR_59_94 |-> ##2
    pll_b_frame_rate_mhz_out == `CCX_MHZ_59_94)
    else $error("code 0110 not read as 59.94 Hz");
  chk_rate_rsvd: assert property ( // RULE6
    fr_in[3] |=> in_frame_rate_mhz_out == `CCX_MHZ_NONE)
    else $error("undefined frame-rate code gave a rate");

  cov_sel_write: cover property (reg_wr_in && sel_hit ##2 xpt_reserved_out == 1'b0);
  cov_force_a: cover property (video_pll_off_force[`CCX_FRC_A_EN] ##1 video_pll_a_off_out);
  cov_reserved: cover property (xpt_sel > `CCX_XPT_BR ##1 xpt_reserved_out);
endmodule

// ### tb/ccx_xpt_tb_top.sv
// Self-checking testbench for the clock output crosspoint select block
`timescale 1ns/1ns
`include "ccx_cfg.svh"
module ccx_xpt_tb_top;
  import ccx_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  ccx_src_t first_src;
  ccx_src_t second_src;
  logic a_off;
  logic b_off;
  logic rsv;
  logic [16:0] rate [3];
  logic [7:0] rd_val;
  logic [3:0] xc;
  logic [3:0] fc;
  logic [3:0] rc [3];
  int error_cnt = 0;
  int comparisons = 0;

  ccx_xpt i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .first_clock_output_src_out(first_src), .second_clock_output_src_out(second_src),
    .video_pll_a_off_out(a_off), .video_pll_b_off_out(b_off), .xpt_reserved_out(rsv),
    .in_frame_rate_mhz_out(rate[0]), .pll_a_frame_rate_mhz_out(rate[1]),
    .pll_b_frame_rate_mhz_out(rate[2])
  );

  // 20 MHz clock
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end

  // Expected sources as {first, second}
  function automatic logic [3:0] exp_src(input logic [3:0] c);
    case (c)
      4'h0: return {CCX_SRC_A, CCX_SRC_B};
      4'h1: return {CCX_SRC_REF, CCX_SRC_REF};
      4'h2: return {CCX_SRC_A, CCX_SRC_A};
      4'h3: return {CCX_SRC_B, CCX_SRC_B};
      4'h4: return {CCX_SRC_B, CCX_SRC_A};
      4'h5: return {CCX_SRC_REF, CCX_SRC_B};
      4'h6: return {CCX_SRC_A, CCX_SRC_REF};
      4'h7: return {CCX_SRC_REF, CCX_SRC_A};
      4'h8: return {CCX_SRC_B, CCX_SRC_REF};
      default: return {CCX_SRC_NONE, CCX_SRC_NONE};
    endcase
  endfunction

  // Expected {a_off, b_off}; forced value wins where enabled
  function automatic logic [1:0] exp_off(input logic [3:0] c, input logic [3:0] f);
    logic [1:0] d;
    case (c)
      4'h1: d = 2'h3;
      4'h3, 4'h5, 4'h8: d = 2'h2;
      4'h2, 4'h6, 4'h7: d = 2'h1;
      default: d = 2'h0;
    endcase
    return {f[0] ? f[1] : d[1], f[2] ? f[3] : d[0]};
  endfunction

  // Frame rate in millihertz; undefined codes give zero
  function automatic logic [16:0] exp_rate(input logic [3:0] c);
    case (c)
      4'h0: return 17'h05dac;
      4'h1: return 17'h05dc0;
      4'h2: return 17'h061a8;
      4'h3: return 17'h07512;
      4'h4: return 17'h07530;
      4'h5: return 17'h0c350;
      4'h6: return 17'h0ea24;
      4'h7: return 17'h0ea60;
      default: return 17'h00000;
    endcase
  endfunction

  task automatic report(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_src(input logic [3:0] got, input logic [3:0] exp);
    report({13'h0000, got}, {13'h0000, exp});
  endtask

  task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
    report({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic cmp_word(input logic [16:0] got, input logic [16:0] exp);
    report(got, exp);
  endtask

  // One strobe cycle, then an idle edge so back-to-back calls never toggle a strobe twice
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge mclk_in);
    #1;
    reg_wr_in = 1'b0;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge mclk_in);
    #1;
    reg_rd_in = 1'b0;
    rd_val = reg_rdata_out;
    @(posedge mclk_in);
    #1;
  endtask

  // Derived outputs land one edge after the write edge
  task automatic settle();
    @(posedge mclk_in);
    #1;
  endtask

  task automatic check_out();
    cmp_src({first_src, second_src}, exp_src(xc));
    cmp_flag({a_off, b_off}, exp_off(xc, fc));
    cmp_flag({1'b0, rsv}, {1'b0, xc > 4'h8});
    for (int i = 0; i < 3; i++) begin
      cmp_word(rate[i], exp_rate(rc[i]));
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 600 cycles the tests need
  initial begin
    #(50 * 4000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h7cb5));
    xc = 4'h0;
    fc = 4'h0;
    rc = '{4'h0, 4'h0, 4'h0};
    repeat (2) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    check_out();
    reg_read(`CCX_ADDR_XPT);
    cmp_word({9'h000, rd_val}, 17'h00000);
    $display("test reset values done");
    // Every select code, reserved ones too, with junk in the upper bits
    for (int c = 0; c < 16; c++) begin
      xc = 4'(c);
      reg_write(`CCX_ADDR_XPT, {4'($urandom), xc});
      settle();
      check_out();
      reg_read(`CCX_ADDR_XPT);
      cmp_word({9'h000, rd_val}, {13'h0000, xc});
    end
    $display("test select decode done");
    // Random select and force pairs written back to back
    for (int n = 0; n < 32; n++) begin
      xc = 4'($urandom_range(8, 0));
      fc = 4'($urandom);
      reg_write(`CCX_ADDR_XPT, {4'h0, xc});
      reg_write(`CCX_ADDR_FORCE, {4'h0, fc});
      settle();
      check_out();
      reg_read(`CCX_ADDR_FORCE);
      cmp_word({9'h000, rd_val}, {13'h0000, fc});
    end
    $display("test force done");
    // Each frame-rate register through every code; others must stay
    for (int a = 0; a < 3; a++) begin
      for (int c = 0; c < 16; c++) begin
        rc[a] = 4'(c);
        reg_write(`CCX_ADDR_FR_IN + 8'(a), {4'($urandom), rc[a]});
        settle();
        check_out();
        reg_read(`CCX_ADDR_FR_IN + 8'(a));
        cmp_word({9'h000, rd_val}, {13'h0000, rc[a]});
      end
    end
    $display("test frame rates done");
    // Unmapped places read zero and writes there change nothing
    for (int k = 0; k < 4; k++) begin
      reg_write(8'(k * 8'h1b + 8'h0b), 8'($urandom));
      reg_read(8'(k * 8'h1b + 8'h0b));
      cmp_word({9'h000, rd_val}, 17'h00000);
      settle();
      check_out();
    end
    $display("test unmapped done");
    // Second reset in mid-run restores every value
    rst_in = 1'b1;
    @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    xc = 4'h0;
    fc = 4'h0;
    rc = '{4'h0, 4'h0, 4'h0};
    check_out();
    reg_read(`CCX_ADDR_XPT);
    cmp_word({9'h000, rd_val}, 17'h00000);
    $display("test second reset done");
    give_verdict();
  end
endmodule
